// File: design/opp_pkg.sv
// Constants shared by the byte-wide PROM programmer controller.
// Assumes a 100 MHz reference clock and the device strapped into its PROM mode.
package opp_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned ADDR_W = 17;
  localparam int unsigned DATA_W = 8;
  localparam logic [16:0] ADDR_LOW = 17'h00000;
  localparam logic [16:0] ADDR_TOP = 17'h0EDFF;
  localparam logic [16:0] ADDR_FIRST_UNIMPL = 17'h0EE00;
  localparam logic [16:0] ADDR_SPACE_TOP = 17'h1FFFF;
  localparam logic [7:0] BLANK_BYTE = 8'hFF;
  // Pulse widths in microseconds, as printed in milliseconds times 1000.
  localparam int unsigned PROGRAM_PULSE_WIDTH_US = 200;
  localparam int unsigned OVERWRITE_PULSE_MIN_US = 190;
  localparam int unsigned OVERWRITE_PULSE_MAX_US = 5250;
  localparam int unsigned PROGRAM_PULSE_CYC = PROGRAM_PULSE_WIDTH_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned OVERWRITE_MIN_CYC =
    (OVERWRITE_PULSE_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OVERWRITE_MAX_CYC = OVERWRITE_PULSE_MAX_US * 1000 / CLK_PERIOD_NS;
  // Setup and hold margins, 2 us each.
  localparam int unsigned SETUP_US = 2;
  localparam int unsigned SETUP_CYC = SETUP_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned TRIES_RESET = 0;
  localparam int unsigned MAX_TRIES = 25;
  localparam int unsigned CNT_W = 20;
endpackage : opp_pkg

// File: design/opp_buf2.sv
// Two-entry buffer with valid and ready on both sides.
// Assumes a single clock; the clock enable freezes all state.
`timescale 1ns/1ps
`default_nettype none
module opp_buf2 #(
  parameter int unsigned WIDTH = 25
) (
  // Clock and control
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  logic [WIDTH-1:0] mem_q [2];
  logic [WIDTH-1:0] mem_d [2];
  logic rd_q, rd_d, wr_q, wr_d;
  logic [1:0] cnt_q, cnt_d;
  logic rdy_q, rdy_d;
  logic push, pop;

  always_comb
  begin
    push = in_valid_i && (cnt_q != 2'h2);
    pop = (cnt_q != 2'h0) && out_ready_i;
    mem_d = mem_q;
    if (push)
    begin
      mem_d[wr_q] = in_data_i;
    end
    wr_d = push ? ~wr_q : wr_q;
    rd_d = pop ? ~rd_q : rd_q;
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
    // Ready is kept in its own flop so the upstream port sees no gate delay.
    rdy_d = (cnt_d != 2'h2);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      cnt_q <= 2'h0;
      rdy_q <= 1'b1;
    end
    else if (en_i)
    begin
      mem_q <= mem_d;
      rd_q <= rd_d;
      wr_q <= wr_d;
      cnt_q <= cnt_d;
      rdy_q <= rdy_d;
    end
  end

  assign in_ready_o = rdy_q;
  assign out_valid_o = (cnt_q != 2'h0);
  assign out_data_o = mem_q[rd_q];
endmodule // opp_buf2
`default_nettype wire

// File: design/opp_prog.sv
// PROM programmer controller: takes address/data words from a stream and
// writes each byte up to the array top with a write-then-verify loop on the device pins.
// Assumes the device is already strapped into PROM mode and its data pins are
// asynchronous to ref_clk_i; the programming voltage is handled elsewhere.
//
// Summary of operation
// RULE_01 - Pin pattern picks write, verify or inhibit.
// RULE_02 - One byte per program cycle, never pages.
// RULE_03 - Pulse, verify, repeat until byte matches; the code stops after MAX_TRIES pulses and reports a failure.
// RULE_04 - Only program addresses up to the top.
// RULE_05 - Never program at or above unimplemented start.
// RULE_06 - Image above array holds all-ones bytes.
// RULE_07 - Initial pulse nominal, overwrite within limits.
// RULE_08 - Device enters PROM mode only by straps.
// RULE_09 - Device drives data only during verify.
`timescale 1ns/1ps
`default_nettype none
module opp_prog #(
  parameter int unsigned ADDR_W = opp_pkg::ADDR_W,
  parameter int unsigned DATA_W = opp_pkg::DATA_W,
  parameter int unsigned PULSE_CYC = opp_pkg::PROGRAM_PULSE_CYC,
  parameter int unsigned OVW_CYC = opp_pkg::OVERWRITE_MIN_CYC,
  parameter int unsigned SETUP_CYC = opp_pkg::SETUP_CYC,
  parameter int unsigned MAX_TRIES = opp_pkg::MAX_TRIES
) (
  // Clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  // Request stream: address and byte to program
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic [DATA_W-1:0] req_data_i,
  // Result stream
  output logic rsp_valid_o,
  input wire logic rsp_ready_i,
  output logic rsp_ok_o,
  output logic rsp_skipped_o,
  output logic [DATA_W-1:0] rsp_readback_o,
  // Device pins
  output logic chip_select_n_o,
  output logic output_gate_n_o,
  output logic program_strobe_n_o,
  output logic [ADDR_W-1:0] prom_address_bus_o,
  output logic [DATA_W-1:0] prom_data_bus_o,
  output logic prom_data_bus_oe_o,
  input wire logic [DATA_W-1:0] prom_data_bus_i
);
  typedef enum logic [2:0] {
    OPP_IDLE, OPP_SETUP, OPP_PULSE, OPP_HOLD, OPP_VSETUP, OPP_VREAD, OPP_DONE
  } opp_state_t;

  localparam int unsigned CNT_W = opp_pkg::CNT_W;
  localparam int unsigned BW = ADDR_W + DATA_W;

  //////////////////////////////////////////////////////////////////////////////
  // Input buffer and pin synchroniser.

  logic buf_valid, buf_ready;
  logic [BW-1:0] buf_data;
  logic [DATA_W-1:0] sync1_q, sync2_q;

  opp_buf2 #(.WIDTH(BW)) u_buf (
    .clk_i(ref_clk_i),
    .rst_i(sys_rst_i),
    .en_i(clk_en_i),
    .in_valid_i(req_valid_i),
    .in_ready_o(req_ready_o),
    .in_data_i({req_addr_i, req_data_i}),
    .out_valid_o(buf_valid),
    .out_ready_i(buf_ready),
    .out_data_o(buf_data)
  );

  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else if (clk_en_i)
    begin
      sync1_q <= prom_data_bus_i;
      sync2_q <= sync1_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Write-then-verify sequencer.

  opp_state_t st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [7:0] tries_q, tries_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] data_q, data_d, rb_q, rb_d;
  logic ce_q, ce_d, oe_q, oe_d, pgm_q, pgm_d, drv_q, drv_d;
  logic rv_q, rv_d, ok_q, ok_d, skip_q, skip_d;

  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    tries_d = tries_q;
    addr_d = addr_q;
    data_d = data_q;
    rb_d = rb_q;
    ce_d = ce_q;
    oe_d = oe_q;
    pgm_d = pgm_q;
    drv_d = drv_q;
    rv_d = rv_q;
    ok_d = ok_q;
    skip_d = skip_q;
    buf_ready = 1'b0;
    if (rv_q && rsp_ready_i)
    begin
      rv_d = 1'b0;
    end
    case (st_q)
      OPP_IDLE:
      begin
        // Inhibit pattern: all controls high, bus released.
        ce_d = 1'b1; // RULE_01
        oe_d = 1'b1;
        pgm_d = 1'b1;
        drv_d = 1'b0;
        if (buf_valid && !rv_q)
        begin
          buf_ready = 1'b1;
          addr_d = buf_data[BW-1:DATA_W];
          data_d = buf_data[DATA_W-1:0];
          tries_d = 8'h00;
          cnt_d = '0;
          if (buf_data[BW-1:DATA_W] > opp_pkg::ADDR_TOP) // RULE_04 RULE_05
          begin
            // Above the array the image is blank; report and never strobe.
            ok_d = (buf_data[DATA_W-1:0] == opp_pkg::BLANK_BYTE); // RULE_06
            skip_d = 1'b1;
            rb_d = opp_pkg::BLANK_BYTE;
            st_d = OPP_DONE;
          end
          else
          begin
            skip_d = 1'b0;
            st_d = OPP_SETUP;
          end
        end
      end
      OPP_SETUP:
      begin
        // Write pattern: select low, gate high, data driven before strobe.
        ce_d = 1'b0; // RULE_01 RULE_02
        oe_d = 1'b1;
        drv_d = 1'b1;
        cnt_d = cnt_q + CNT_W'(1);
        if (cnt_q == CNT_W'(SETUP_CYC - 1))
        begin
          cnt_d = '0;
          pgm_d = 1'b0;
          st_d = OPP_PULSE;
        end
      end
      OPP_PULSE:
      begin
        cnt_d = cnt_q + CNT_W'(1);
        // First pulse nominal width, later ones overwrite width.
        if ((tries_q == 8'h00 && cnt_q == CNT_W'(PULSE_CYC - 1)) ||
            (tries_q != 8'h00 && cnt_q == CNT_W'(OVW_CYC - 1))) // RULE_07
        begin
          cnt_d = '0;
          pgm_d = 1'b1;
          st_d = OPP_HOLD;
        end
      end
      OPP_HOLD:
      begin
        // Data held past the strobe's rise before the bus is released.
        cnt_d = cnt_q + CNT_W'(1);
        if (cnt_q == CNT_W'(SETUP_CYC - 1))
        begin
          cnt_d = '0;
          drv_d = 1'b0;
          st_d = OPP_VSETUP;
        end
      end
      OPP_VSETUP:
      begin
        // Gate goes low only after our driver is off, avoiding contention.
        oe_d = 1'b0; // RULE_01 RULE_09
        cnt_d = cnt_q + CNT_W'(1);
        if (cnt_q == CNT_W'(SETUP_CYC - 1))
        begin
          cnt_d = '0;
          st_d = OPP_VREAD;
        end
      end
      OPP_VREAD:
      begin
        // Three cycles more let the read byte through the synchroniser.
        cnt_d = cnt_q + CNT_W'(1);
        if (cnt_q == CNT_W'(2))
        begin
          cnt_d = '0;
          oe_d = 1'b1;
          rb_d = sync2_q;
          tries_d = tries_q + 8'h01;
          if (sync2_q == data_q) // RULE_03
          begin
            ok_d = 1'b1;
            st_d = OPP_DONE;
          end
          else if (tries_q == 8'(MAX_TRIES - 1))
          begin
            ok_d = 1'b0;
            st_d = OPP_DONE;
          end
          else
          begin
            st_d = OPP_SETUP;
          end
        end
      end
      OPP_DONE:
      begin
        ce_d = 1'b1;
        oe_d = 1'b1;
        rv_d = 1'b1;
        st_d = OPP_IDLE;
      end
      default:
      begin
        st_d = OPP_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      st_q <= OPP_IDLE;
      cnt_q <= '0;
      tries_q <= 8'h00;
      addr_q <= '0;
      data_q <= '0;
      rb_q <= '0;
      ce_q <= 1'b1;
      oe_q <= 1'b1;
      pgm_q <= 1'b1;
      drv_q <= 1'b0;
      rv_q <= 1'b0;
      ok_q <= 1'b0;
      skip_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      tries_q <= tries_d;
      addr_q <= addr_d;
      data_q <= data_d;
      rb_q <= rb_d;
      ce_q <= ce_d;
      oe_q <= oe_d;
      pgm_q <= pgm_d;
      drv_q <= drv_d;
      rv_q <= rv_d;
      ok_q <= ok_d;
      skip_q <= skip_d;
    end
  end

  assign chip_select_n_o = ce_q;
  assign output_gate_n_o = oe_q;
  assign program_strobe_n_o = pgm_q;
  assign prom_address_bus_o = addr_q;
  assign prom_data_bus_o = data_q;
  assign prom_data_bus_oe_o = drv_q;
  assign rsp_valid_o = rv_q;
  assign rsp_ok_o = ok_q;
  assign rsp_skipped_o = skip_q;
  assign rsp_readback_o = rb_q;
endmodule // opp_prog
`default_nettype wire

// File: tb/opp_prog_asserts.sv
// Pin and result-stream checks for the PROM programmer controller.
// Assumes one clock domain; bound to the controller's top module.
`timescale 1ns/1ps
`default_nettype none
module opp_prog_asserts #(
  parameter int PULSE_CYC = 20000,
  parameter int OVW_CYC = 19000
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Result stream
  input wire logic rsp_valid_o,
  input wire logic rsp_ready_i,
  input wire logic rsp_ok_o,
  input wire logic [7:0] rsp_readback_o,
  // Device pins
  input wire logic chip_select_n_o,
  input wire logic output_gate_n_o,
  input wire logic program_strobe_n_o,
  input wire logic [16:0] prom_address_bus_o,
  input wire logic [7:0] prom_data_bus_o,
  input wire logic prom_data_bus_oe_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  // Long pulses cannot be unrolled, so the low time is counted here.
  logic [19:0] low_q;
  logic [19:0] low_d;
  always_comb low_d = program_strobe_n_o ? 20'h00000 : low_q + 20'h00001;
  always_ff @(posedge ref_clk_i) low_q <= sys_rst_i ? 20'h00000 : low_d;
  property p_wr_pat;
    !program_strobe_n_o |-> !chip_select_n_o && output_gate_n_o && prom_data_bus_oe_o;
  endproperty
  a_wr_pat: assert property (p_wr_pat) else $error("strobe low off write pattern");
  property p_rd_pat;
    !output_gate_n_o |-> !chip_select_n_o && program_strobe_n_o && !prom_data_bus_oe_o;
  endproperty
  a_rd_pat: assert property (p_rd_pat) else $error("gate low off verify pattern");
  property p_idle;
    chip_select_n_o |-> output_gate_n_o && program_strobe_n_o && !prom_data_bus_oe_o;
  endproperty
  a_idle: assert property (p_idle) else $error("pins active while deselected");
  property p_pw;
    $rose(program_strobe_n_o) |-> low_q >= OVW_CYC && low_q <= PULSE_CYC;
  endproperty
  a_pw: assert property (p_pw) else $error("strobe width out of range");
  property p_addr;
    !program_strobe_n_o |-> prom_address_bus_o <= opp_pkg::ADDR_TOP;
  endproperty
  a_addr: assert property (p_addr) else $error("strobe above array top");
  property p_steady;
    !program_strobe_n_o && $past(!program_strobe_n_o) |->
      $stable(prom_address_bus_o) && $stable(prom_data_bus_o);
  endproperty
  a_steady: assert property (p_steady) else $error("byte moved during pulse");
  property p_hold;
    $rose(program_strobe_n_o) |-> (prom_data_bus_oe_o && output_gate_n_o)[*2];
  endproperty
  a_hold: assert property (p_hold) else $error("data dropped after pulse");
  property p_rsp;
    rsp_valid_o && !rsp_ready_i |=> rsp_valid_o && $stable(rsp_ok_o) && $stable(rsp_readback_o);
  endproperty
  a_rsp: assert property (p_rsp) else $error("result changed while stalled");
endmodule // opp_prog_asserts
bind opp_prog opp_prog_asserts #(.PULSE_CYC(PULSE_CYC), .OVW_CYC(OVW_CYC)) u_chk (
  .ref_clk_i, .sys_rst_i, .rsp_valid_o, .rsp_ready_i, .rsp_ok_o, .rsp_readback_o,
  .chip_select_n_o, .output_gate_n_o, .program_strobe_n_o, .prom_address_bus_o,
  .prom_data_bus_o, .prom_data_bus_oe_o);
`default_nettype wire

// File: tb/opp_prom_model.sv
// Behavioural one-time-programmable array seen through its programming pins.
// Assumes the controller drives all pins; need_i sets pulses a cell takes.
`timescale 1ns/1ps
`default_nettype none
module opp_prom_model (
  // Control pins
  input wire logic cs_n_i,
  input wire logic gate_n_i,
  input wire logic strobe_n_i,
  // Address, write data, pulses needed
  input wire logic [16:0] addr_i,
  input wire logic [7:0] data_i,
  input wire logic [7:0] need_i,
  // Read data
  output logic [7:0] data_o
);
  logic [7:0] mem [0:17'h1FFFF];
  logic [7:0] hits [0:17'h1FFFF];
  logic [7:0] last_q = 8'hFF;
  int pulses = 0;
  wire wr = !cs_n_i && gate_n_i && !strobe_n_i;
  wire rd = !cs_n_i && !gate_n_i && strobe_n_i;
  // Always strapped into programming mode; blank cells read all ones.
  initial
  begin
    foreach (mem[i])
    begin
      mem[i] = 8'hFF;
      hits[i] = 8'h00;
    end
  end
  always @(negedge wr)
    if (cs_n_i === 1'b0 && gate_n_i === 1'b1)
    begin
      pulses++;
      hits[addr_i] = hits[addr_i] + 8'h01;
      if (hits[addr_i] >= need_i) mem[addr_i] = data_i;
    end
  always @(negedge rd)
    if (cs_n_i === 1'b0) last_q = mem[addr_i];
  // A released bus shows the inverse of the last byte so late sampling is caught.
  assign data_o = rd ? mem[addr_i] : ~last_q;
endmodule // opp_prom_model
`default_nettype wire

// File: tb/opp_prog_tb.sv
// Self-checking bench for the PROM programmer controller.
// Assumes the device model on the pins and shortened pulse counts.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module opp_prog_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rq_v = 1'b0;
  logic rs_r = 1'b1;
  logic en = 1'b1;
  logic [16:0] rq_a = 17'h00000;
  logic [7:0] rq_d = 8'h00;
  logic [7:0] need = 8'h01;
  logic rq_r, rs_v, rs_ok, rs_sk, cs_n, gt_n, st_n, oe;
  logic [7:0] rs_rb, pd_o, dev_d, pin_d;
  logic [16:0] pa;
  int miscompares = 0;
  int checks_done = 0;
  int cyc = 0;
  initial forever #5 clk = ~clk;
  assign pin_d = oe ? pd_o : dev_d;
  opp_prog #(.PULSE_CYC(10), .OVW_CYC(8), .SETUP_CYC(3), .MAX_TRIES(3)) DUT (
    .ref_clk_i(clk), .sys_rst_i(rst), .clk_en_i(en),
    .req_valid_i(rq_v), .req_ready_o(rq_r), .req_addr_i(rq_a), .req_data_i(rq_d),
    .rsp_valid_o(rs_v), .rsp_ready_i(rs_r), .rsp_ok_o(rs_ok), .rsp_skipped_o(rs_sk),
    .rsp_readback_o(rs_rb), .chip_select_n_o(cs_n), .output_gate_n_o(gt_n),
    .program_strobe_n_o(st_n), .prom_address_bus_o(pa), .prom_data_bus_o(pd_o),
    .prom_data_bus_oe_o(oe), .prom_data_bus_i(pin_d));
  opp_prom_model mdl (.cs_n_i(cs_n), .gate_n_i(gt_n), .strobe_n_i(st_n), .addr_i(pa),
    .data_i(pd_o), .need_i(need), .data_o(dev_d));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk)
    if (++cyc == 5000)
    begin
      miscompares++;
      report_and_stop();
    end
  // Valid stays up between words unless this is the last of a burst.
  task automatic send(input logic [16:0] a, input logic [7:0] d, input logic last);
    rq_v <= 1'b1;
    rq_a <= a;
    rq_d <= d;
    do @(negedge clk); while (rq_r !== 1'b1);
    @(posedge clk);
    if (last) rq_v <= 1'b0;
  endtask
  task automatic chk_rsp(input logic ok, input logic sk, input logic [7:0] rb);
    int n;
    n = 0;
    do @(negedge clk); while (rs_v !== 1'b1 && ++n < 3000);
    `CHK(rs_v, 1'b1)
    `CHK(rs_ok, ok)
    `CHK(rs_sk, sk)
    `CHK(rs_rb, rb)
    @(posedge clk);
  endtask
  task automatic prog(input logic [16:0] a, input logic [7:0] d, input logic ok,
                      input logic sk, input logic [7:0] rb, input int np);
    int p;
    p = mdl.pulses;
    send(a, d, 1'b1);
    chk_rsp(ok, sk, rb);
    `CHK(mdl.pulses - p, np)
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_write();
    prog(17'h00000, 8'h5A, 1'b1, 1'b0, 8'h5A, 1);
    prog(17'h0EDFF, 8'h00, 1'b1, 1'b0, 8'h00, 1);
    `CHK(mdl.mem[17'h0EDFF], 8'h00)
  endtask
  task automatic t_retry();
    need = 8'h03;
    prog(17'h00100, 8'hA5, 1'b1, 1'b0, 8'hA5, 3);
  endtask
  task automatic t_fail();
    need = 8'hFF;
    prog(17'h00200, 8'h3C, 1'b0, 1'b0, 8'hFF, 3);
  endtask
  task automatic t_skip();
    prog(17'h0EE00, 8'hFF, 1'b1, 1'b1, 8'hFF, 0);
    prog(17'h1FFFF, 8'h12, 1'b0, 1'b1, 8'hFF, 0);
  endtask
  // Results are stalled so the buffer fills; order is shown by the ok flags.
  task automatic t_buf();
    rs_r <= 1'b0;
    send(17'h0EE01, 8'hFF, 1'b0);
    send(17'h0EE02, 8'h00, 1'b0);
    send(17'h0EE03, 8'hFF, 1'b1);
    repeat (8) @(posedge clk);
    @(negedge clk);
    `CHK(rq_r, 1'b0)
    `CHK(rs_v, 1'b1)
    @(posedge clk);
    rs_r <= 1'b1;
    chk_rsp(1'b1, 1'b1, 8'hFF);
    chk_rsp(1'b0, 1'b1, 8'hFF);
    chk_rsp(1'b1, 1'b1, 8'hFF);
  endtask
  // Enable low must hold off the take and every step after it.
  task automatic t_freeze();
    en <= 1'b0;
    rq_v <= 1'b1;
    rq_a <= 17'h0EE04;
    rq_d <= 8'hFF;
    repeat (6) @(posedge clk);
    @(negedge clk);
    `CHK(rs_v, 1'b0)
    @(posedge clk);
    en <= 1'b1;
    @(posedge clk);
    rq_v <= 1'b0;
    chk_rsp(1'b1, 1'b1, 8'hFF);
  endtask
  // A reset in mid-pulse must drop select, strobe and the bus driver back to the inhibit pattern.
  task automatic t_reset();
    send(17'h00300, 8'h0F, 1'b1);
    repeat (6) @(posedge clk);
    @(negedge clk);
    `CHK(st_n, 1'b0)
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (3)
    begin
      @(negedge clk);
      `CHK(cs_n, 1'b1)
      `CHK(st_n, 1'b1)
      `CHK(oe, 1'b0)
      `CHK(rs_v, 1'b0)
    end
    @(posedge clk);
    need = 8'h01;
    prog(17'h00301, 8'h0F, 1'b1, 1'b0, 8'h0F, 1);
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    `CHK(cs_n, 1'b1)
    `CHK(oe, 1'b0)
    @(posedge clk);
    t_write();
    t_retry();
    t_fail();
    t_skip();
    t_buf();
    t_freeze();
    t_reset();
    report_and_stop();
  end
endmodule // opp_prog_tb
`default_nettype wire
